// ===== hdl/rxdwb_pkg.sv
package rxdwb_pkg;

  // ----------------------------------------------------------------
  // Register map (APB byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_BASE = 8'h04;
  localparam logic [7:0] ADDR_STAT = 8'h08;
  localparam logic [7:0] ADDR_LAST0 = 8'h0c;
  localparam logic [7:0] ADDR_LAST1 = 8'h10;

  // Control register fields
  localparam int CTRL_FMT_LSB = 0;
  localparam int CTRL_FMT_W = 8;
  localparam int CTRL_LOOKAHEAD_CHAIN_ENABLE_BIT = 8;
  localparam int CTRL_LABEL_BIT = 9;
  localparam int CTRL_BREJ_BIT = 10;
  localparam int CTRL_STRIP_BIT = 11;
  localparam int CTRL_LOOP_BIT = 12;
  localparam int CTRL_EN_BIT = 13;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // Format select values
  localparam logic [7:0] FMT_16BIT = 8'h00;
  localparam logic [7:0] FMT_TAG = 8'h03;
  localparam logic [7:0] FMT_VLAN = 8'h04;

  // ----------------------------------------------------------------
  // Descriptor layout
  // ----------------------------------------------------------------
  localparam logic [31:0] DESC_STRIDE = 32'h0000_0010;
  localparam logic [31:0] OFS_LEN = 32'h0000_0000;
  localparam logic [31:0] OFS_STATUS = 32'h0000_0004;
  localparam logic [31:0] OFS_BUFPTR = 32'h0000_0008;
  localparam logic [31:0] OFS_USER = 32'h0000_000c;
  localparam int OWN_BIT = 31;
  localparam int ERR_BIT = 30;
  localparam int ALIGN_BIT = 29;
  localparam int FIFO_OVERRUN_FLAG_BIT = 28;
  localparam int FCS_BIT = 27;
  localparam int FIRST_BIT = 25;
  localparam int LAST_BIT = 24;
  localparam int UCAST_BIT = 22;
  localparam int HASH_BIT = 21;
  localparam int BCAST_BIT = 20;
  localparam int TAGK_LSB = 18;
  localparam int HI_LSB = 16;
  localparam logic [1:0] TAGK_UNTAGGED = 2'h1;
  localparam logic [1:0] TAGK_PRIO = 2'h2;
  localparam logic [1:0] TAGK_VLAN = 2'h3;

  // Length reporting
  localparam logic [15:0] STRIP_LIMIT = 16'h002e;
  localparam logic [15:0] HDR_BYTES = 16'h000e;

  // Frame report from the receive path
  typedef struct packed {
    logic [15:0] rx_len;
    logic [15:0] len_field;
    logic odd_bits;
    logic fcs_bad;
    logic mii_err;
    logic overrun;
    logic last;
    logic da_ucast;
    logic da_bcast;
    logic hash_pass;
    logic [14:0] label;
    logic [15:0] tci;
    logic [1:0] tag_kind;
  } rxdwb_report_t;

  // Memory master request
  typedef struct packed {
    logic wr;
    logic [31:0] addr;
    logic [31:0] wdata;
  } rxdwb_mreq_t;

endpackage : rxdwb_pkg

// ===== hdl/rxdwb_top.sv
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/100ps
// Summary of operation
// - Bit 31 owns entry; host sets after emptying, device clears after filling.
// - Party that gave up ownership never touches the entry again.
// - Error summary bit 30 is OR of alignment, overrun, FCS errors.
// - Alignment fault needs odd bit count and FCS failure together.
// - Alignment and FCS bits meaningful only at last buffer without overrun.
// - Overrun bit 28 set when frame data lost to FIFO overflow.
// - FCS error bit 27 on FCS mismatch or MII receive error.
// - First-buffer bit 25 set by device unless lookahead chaining enabled.
// - Last-buffer bit 24 marks final buffer of a frame.
// - Unicast match bit 22 for physical address acceptance, last buffer only.
// - Hash match bit 21 for hash filter acceptance, last buffer only.
// - Broadcast with reject clear sets only broadcast match, not hash.
// - Broadcast match bit 20 for broadcast acceptance, last buffer only.
// - Address-match bits absent in 16-bit descriptor format.
// - Buffer length field bits 15-0 is read, never modified.
// - Length includes FCS; stripped short frames report 14 plus length field.
// - Received length written in bits 15-0 of word offset 0.
// - Tag layout puts frame label in bits 30-16; zero when disabled.
// - VLAN layout copies tag control information into bits 31-16.
// - VLAN layout tag kind bits 19-18: 01, 10, 11; never 00.
// - Buffer pointer read from offset 8; offset 0Ch never accessed.
// - Format 3 tag layout, 4 VLAN layout, 0 16-bit structures.
module rxdwb_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rpt_valid,
  output logic rpt_ready,
  input wire rxdwb_pkg::rxdwb_report_t rpt,
  output rxdwb_pkg::rxdwb_mreq_t mreq,
  output logic mreq_valid,
  input wire logic mreq_ready,
  input wire logic [31:0] mrdata,
  output logic [31:0] buf_ptr,
  output logic buf_ptr_valid
);
  import rxdwb_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE, ST_RD_STAT, ST_RD_PTR, ST_WR_LEN, ST_WR_STAT
  } rxdwb_state_t;

  rxdwb_state_t state_reg;
  logic [31:0] ctrl_reg;
  logic [31:0] base_reg;
  logic [31:0] stat_reg;
  logic [31:0] last_len_reg;
  logic [31:0] last_stat_reg;
  rxdwb_report_t rpt_reg;
  logic [31:0] host_stat_reg;
  logic [31:0] len_word;
  logic [31:0] stat_word;
  logic [31:0] desc_addr;
  logic [7:0] fmt;
  logic fmt_ok;
  logic fmt32;
  logic apb_wr;
  logic apb_acc;
  logic [15:0] rep_len;
  logic fcs_err;
  logic align_err;
  logic bcast_only;
  logic err_sum;
  logic own_seen;

  assign fmt = ctrl_reg[CTRL_FMT_LSB +: CTRL_FMT_W];
  // Format select decode
  assign fmt_ok = (fmt == FMT_TAG) || (fmt == FMT_VLAN);
  assign fmt32 = (fmt != FMT_16BIT);
  assign desc_addr = base_reg;

  // ----------------------------------------------------------------
  // APB slave: zero wait states, unmapped reads zero with error
  // ----------------------------------------------------------------
  assign pready = 1'b1;
  assign apb_acc = psel && penable;
  assign apb_wr = apb_acc && pwrite;

  always_comb begin
    prdata = 32'h0000_0000;
    pslverr = 1'b0;
    if (apb_acc) begin
      unique case (paddr)
        ADDR_CTRL: prdata = ctrl_reg;
        ADDR_BASE: prdata = base_reg;
        ADDR_STAT: prdata = stat_reg;
        ADDR_LAST0: prdata = last_len_reg;
        ADDR_LAST1: prdata = last_stat_reg;
        default: pslverr = 1'b1;
      endcase
    end
  end

  // Control register, software only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= CTRL_RESET;
    end else if (apb_wr && paddr == ADDR_CTRL) begin
      ctrl_reg <= pwrite ? pwdata : ctrl_reg;
    end
  end

  // Descriptor pointer; advances one stride after each handed-back entry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      base_reg <= 32'h0000_0000;
    end else if (state_reg == ST_WR_STAT && mreq_ready) begin
      base_reg <= base_reg + DESC_STRIDE;
    end else if (apb_wr && paddr == ADDR_BASE) begin
      base_reg <= pwdata;
    end
  end

  // ----------------------------------------------------------------
  // Field computation
  // ----------------------------------------------------------------
  // Short stripped frames report header plus length field
  always_comb begin
    rep_len = rpt_reg.rx_len;
    if (ctrl_reg[CTRL_STRIP_BIT] && rpt_reg.len_field < STRIP_LIMIT) begin
      rep_len = HDR_BYTES + rpt_reg.len_field;
    end
  end

  // FCS and alignment bits only land in the final buffer with no overrun
  assign fcs_err = rpt_reg.last && !rpt_reg.overrun &&
                   (rpt_reg.fcs_bad || rpt_reg.mii_err);
  // Odd bit count alone is harmless; loopback gives it no meaning
  assign align_err = rpt_reg.last && !rpt_reg.overrun && rpt_reg.odd_bits &&
                     rpt_reg.fcs_bad && !ctrl_reg[CTRL_LOOP_BIT];
  assign err_sum = align_err || rpt_reg.overrun || fcs_err;
  // Broadcast with reject clear suppresses the hash flag
  assign bcast_only = rpt_reg.da_bcast && !ctrl_reg[CTRL_BREJ_BIT];

  // Length word: label or tag info above, count below
  always_comb begin
    len_word = 32'h0000_0000;
    len_word[15:0] = rep_len;
    if (fmt == FMT_TAG && ctrl_reg[CTRL_LABEL_BIT]) begin
      len_word[30:HI_LSB] = rpt_reg.label;
    end else if (fmt == FMT_VLAN) begin
      len_word[31:HI_LSB] = rpt_reg.tci;
    end
  end

  // Status word; low half keeps the host's buffer length untouched
  always_comb begin
    stat_word = 32'h0000_0000;
    stat_word[OWN_BIT] = 1'b0;
    stat_word[ERR_BIT] = err_sum;
    stat_word[ALIGN_BIT] = align_err;
    stat_word[FIFO_OVERRUN_FLAG_BIT] = rpt_reg.overrun;
    stat_word[FCS_BIT] = fcs_err;
    // Host owns the first flag in lookahead mode, so pass its copy back
    stat_word[FIRST_BIT] = ctrl_reg[CTRL_LOOKAHEAD_CHAIN_ENABLE_BIT] ? host_stat_reg[FIRST_BIT]
                                                     : 1'b1;
    stat_word[LAST_BIT] = rpt_reg.last;
    if (fmt32 && rpt_reg.last) begin
      stat_word[UCAST_BIT] = rpt_reg.da_ucast;
      stat_word[HASH_BIT] = rpt_reg.hash_pass && !bcast_only;
      stat_word[BCAST_BIT] = rpt_reg.da_bcast;
    end
    if (fmt == FMT_VLAN) begin
      stat_word[TAGK_LSB +: 2] = (rpt_reg.tag_kind == 2'h0) ? TAGK_UNTAGGED
                                                            : rpt_reg.tag_kind;
    end
    stat_word[15:0] = host_stat_reg[15:0];
  end

  // ----------------------------------------------------------------
  // Descriptor sequencer
  // ----------------------------------------------------------------
  // Report accepted only when idle, enabled and format supported
  assign rpt_ready = (state_reg == ST_IDLE) && ctrl_reg[CTRL_EN_BIT] && fmt_ok;
  assign own_seen = mrdata[OWN_BIT];

  // Status word is last so ownership returns after all fields land
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
    end else begin
      unique case (state_reg)
        ST_IDLE: if (rpt_valid && rpt_ready) state_reg <= ST_RD_STAT;
        ST_RD_STAT: begin
          // Not ours yet: poll again, leave the entry alone
          if (mreq_ready && own_seen) state_reg <= ST_RD_PTR;
        end
        ST_RD_PTR: if (mreq_ready) state_reg <= ST_WR_LEN;
        ST_WR_LEN: if (mreq_ready) state_reg <= ST_WR_STAT;
        ST_WR_STAT: if (mreq_ready) state_reg <= ST_IDLE;
      endcase
    end
  end

  // Frame report capture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rpt_reg <= '0;
    end else if (rpt_valid && rpt_ready) begin
      rpt_reg <= rpt;
    end
  end

  // Host-owned status word copy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_stat_reg <= 32'h0000_0000;
    end else if (state_reg == ST_RD_STAT && mreq_ready) begin
      host_stat_reg <= mrdata;
    end
  end

  // Buffer pointer handed to the data mover
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buf_ptr <= 32'h0000_0000;
      buf_ptr_valid <= 1'b0;
    end else if (state_reg == ST_RD_PTR && mreq_ready) begin
      buf_ptr <= mrdata;
      buf_ptr_valid <= 1'b1;
    end else if (state_reg == ST_IDLE) begin
      buf_ptr_valid <= 1'b0;
    end
  end

  // Memory request; offset 0Ch is never addressed
  always_comb begin
    mreq = '0;
    mreq_valid = 1'b1;
    unique case (state_reg)
      ST_IDLE: mreq_valid = 1'b0;
      ST_RD_STAT: mreq.addr = desc_addr + OFS_STATUS;
      ST_RD_PTR: mreq.addr = desc_addr + OFS_BUFPTR;
      ST_WR_LEN: begin
        mreq.wr = 1'b1;
        mreq.addr = desc_addr + OFS_LEN;
        mreq.wdata = len_word;
      end
      ST_WR_STAT: begin
        mreq.wr = 1'b1;
        mreq.addr = desc_addr + OFS_STATUS;
        mreq.wdata = stat_word;
      end
    endcase
  end

  // Status and last written words for software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_reg <= 32'h0000_0000;
      last_len_reg <= 32'h0000_0000;
      last_stat_reg <= 32'h0000_0000;
    end else begin
      stat_reg <= {28'h0000000, buf_ptr_valid, fmt_ok, 1'b0,
                   state_reg != ST_IDLE};
      if (state_reg == ST_WR_LEN && mreq_ready) last_len_reg <= len_word;
      if (state_reg == ST_WR_STAT && mreq_ready) last_stat_reg <= stat_word;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_own_released: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == ST_WR_STAT) |-> !mreq.wdata[OWN_BIT])
    else $error("ownership flag not cleared on write-back");
  a_err_summary: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == ST_WR_STAT) |-> (mreq.wdata[ERR_BIT] == (mreq.wdata[ALIGN_BIT] ||
      mreq.wdata[FIFO_OVERRUN_FLAG_BIT] || mreq.wdata[FCS_BIT])))
    else $error("error summary mismatch");
  a_align_needs_fcs: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == ST_WR_STAT && mreq.wdata[ALIGN_BIT]) |-> mreq.wdata[FCS_BIT])
    else $error("alignment fault without fcs error");
  a_buflen_kept: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == ST_WR_STAT) |-> (mreq.wdata[15:0] == host_stat_reg[15:0]))
    else $error("buffer length modified");
  a_no_user_word: assert property (@(posedge pclk) disable iff (!presetn)
    mreq_valid |-> (mreq.addr != desc_addr + OFS_USER))
    else $error("user word accessed");
  a_len_before_own: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == ST_WR_LEN && mreq_ready) |=> (state_reg == ST_WR_STAT))
    else $error("length not followed by status write");
  a_no_match_16bit: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == ST_WR_STAT && !fmt32) |-> (mreq.wdata[22:20] == 3'h0))
    else $error("match bits in 16-bit format");
  a_bcast_no_hash: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == ST_WR_STAT && bcast_only) |-> !mreq.wdata[HASH_BIT])
    else $error("hash match on accepted broadcast");
  a_tag_kind_legal: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == ST_WR_STAT && fmt == FMT_VLAN) |-> (mreq.wdata[19:18] != 2'h0))
    else $error("reserved tag kind written");
  a_strip_len: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == ST_WR_LEN && ctrl_reg[CTRL_STRIP_BIT] && rpt_reg.len_field < STRIP_LIMIT)
    |-> (mreq.wdata[15:0] == HDR_BYTES + rpt_reg.len_field))
    else $error("stripped length wrong");

endmodule : rxdwb_top

// ===== bench/rxdwb_mem.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// Descriptor memory on the far side of the write-back master
// ------------------------------------------------------------
module rxdwb_mem
  import rxdwb_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire rxdwb_pkg::rxdwb_mreq_t mreq,
  input wire logic mreq_valid,
  output logic mreq_ready,
  output logic [31:0] mrdata,
  input wire logic slow,
  output int viol
);
  logic [31:0] mem [0:255];
  logic [31:0] last_q;
  logic phase;
  logic len_done;
  logic [7:0] wi;
  logic [3:0] ofs;
  assign wi = mreq.addr[9:2];
  assign ofs = mreq.addr[3:0];
  // Slow mode grants every other cycle only
  assign mreq_ready = mreq_valid && (!slow || phase);
  // Idle bus shows the inverse of the last word, never a stale copy
  assign mrdata = (mreq_ready && !mreq.wr) ? mem[wi] : ~last_q;
  initial viol = 0;
  // Grant phase, stored data and ownership bookkeeping
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase <= 1'b0;
      len_done <= 1'b0;
      last_q <= 32'h0;
    end else begin
      phase <= ~phase;
      if (mreq_valid && mreq_ready) begin
        // Writes only byte offsets 0 and 4 of an owned entry, length word first
        viol <= viol + int'(ofs == 4'hc) + int'(mreq.wr && (ofs[3] ||
          !mem[{wi[7:2], 2'h1}][31] || (ofs == 4'h4 && !len_done)));
        if (mreq.wr) begin
          mem[wi] <= mreq.wdata;
          len_done <= (ofs == 4'h0);
        end else begin
          last_q <= mem[wi];
        end
      end
    end
  end
endmodule : rxdwb_mem

// ===== bench/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import rxdwb_pkg::*;
  typedef struct {
    logic [31:0] ctrl, pre;
    rxdwb_report_t r;
    logic [31:0] elen, estat, mask;
  } rxdwb_case_t;
  localparam logic [31:0] P = 32'h8000_f000;
  localparam logic [31:0] A = 32'hffff_ffff;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic rpt_valid, rpt_ready, mreq_valid, mreq_ready, buf_ptr_valid, slow, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, mrdata, buf_ptr, q;
  rxdwb_report_t rpt;
  rxdwb_mreq_t mreq;
  int viol, err_total, samples_checked, w, n;
  rxdwb_case_t tbl [18];

  rxdwb_top i_rxdwb_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rpt_valid(rpt_valid), .rpt_ready(rpt_ready), .rpt(rpt),
    .mreq(mreq), .mreq_valid(mreq_valid), .mreq_ready(mreq_ready), .mrdata(mrdata),
    .buf_ptr(buf_ptr), .buf_ptr_valid(buf_ptr_valid));
  rxdwb_mem i_rxdwb_mem (.pclk(pclk), .presetn(presetn), .mreq(mreq),
    .mreq_valid(mreq_valid), .mreq_ready(mreq_ready), .mrdata(mrdata), .slow(slow),
    .viol(viol));

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  always #5 pclk = ~pclk;

  task give_verdict;
    if (err_total == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : give_verdict

  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // Bounded wait ran out: counted, then straight to the verdict
  task stall(input string nm);
    err_total++;
    $display("CHECK FAILED %s expected answer seen timeout", nm);
    give_verdict();
  endtask : stall

  // Setup, then access held until pready is seen high at a rising edge
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) stall("apb");
    // Same edge that completes the access: take data, then release
    q = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  // Report held until the rising edge at which the block takes it
  task send(input rxdwb_report_t r);
    @(posedge pclk);
    rpt <= r; rpt_valid <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (rpt_ready !== 1'b1 && n < 100);
    if (rpt_ready !== 1'b1) stall("report");
    rpt_valid <= 1'b0;
  endtask : send

  task wait_own(input int wd);
    n = 0;
    do begin @(negedge pclk); n++; end while (i_rxdwb_mem.mem[wd+1][31] !== 1'b0 && n < 300);
    if (i_rxdwb_mem.mem[wd+1][31] !== 1'b0) stall("writeback");
  endtask : wait_own

  // Fixed label and tag control, so expectations stay readable
  function automatic rxdwb_report_t mk(logic [15:0] ln, logic [15:0] lf, logic [7:0] fl,
    logic [1:0] tk);
    return {ln, lf, fl, 15'h7fff, 16'habcd, tk};
  endfunction : mk

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    tbl[0] = '{32'h2003, P, mk(16'h40, 16'h40, 8'h0c, 2'h0), 32'h40, 32'h0340_f000, A};
    tbl[1] = '{32'h2203, P, mk(16'h5ee, 16'h5ee, 8'h09, 2'h0), 32'h7fff_05ee, 32'h0320_f000, A};
    tbl[2] = '{32'h2803, P, mk(16'h40, 16'h2d, 8'h08, 2'h0), 32'h3b, 32'h0300_f000, A};
    tbl[3] = '{32'h2803, P, mk(16'h44, 16'h2e, 8'h08, 2'h0), 32'h44, 32'h0300_f000, A};
    tbl[4] = '{32'h2003, P, mk(16'h50, 16'h50, 8'hc8, 2'h0), 32'h50, 32'h6b00_f000, A};
    tbl[5] = '{32'h2003, P, mk(16'h50, 16'h50, 8'h88, 2'h0), 32'h50, 32'h0300_f000, A};
    tbl[6] = '{32'h2003, P, mk(16'h50, 16'h50, 8'h28, 2'h0), 32'h50, 32'h4b00_f000, A};
    tbl[7] = '{32'h2003, P, mk(16'h50, 16'h50, 8'h18, 2'h0), 32'h50, 32'h5300_f000, A};
    tbl[8] = '{32'h2003, P, mk(16'h50, 16'h50, 8'h44, 2'h0), 32'h50, 32'h0200_f000, A};
    tbl[9] = '{32'h2103, P, mk(16'h50, 16'h50, 8'h08, 2'h0), 32'h50, 32'h0100_f000, A};
    tbl[10] = '{32'h2103, 32'h8200_f000, mk(16'h50, 16'h50, 8'h08, 2'h0), 32'h50,
      32'h0300_f000, A};
    tbl[11] = '{32'h2003, P, mk(16'h50, 16'h50, 8'h0b, 2'h0), 32'h50, 32'h0310_f000, A};
    tbl[12] = '{32'h2403, P, mk(16'h50, 16'h50, 8'h0b, 2'h0), 32'h50, 32'h0320_f000,
      32'hffef_ffff};
    tbl[13] = '{32'h2004, P, mk(16'h40, 16'h40, 8'h08, 2'h1), 32'habcd_0040, 32'h0304_f000, A};
    tbl[14] = '{32'h2004, P, mk(16'h40, 16'h40, 8'h08, 2'h2), 32'habcd_0040, 32'h0308_f000, A};
    tbl[15] = '{32'h2004, P, mk(16'h40, 16'h40, 8'h08, 2'h3), 32'habcd_0040, 32'h030c_f000, A};
    tbl[16] = '{32'h2004, P, mk(16'h40, 16'h40, 8'h08, 2'h0), 32'habcd_0040, 32'h0304_f000, A};
    // Internal loopback: odd bit count with bad FCS is no alignment fault
    tbl[17] = '{32'h3003, P, mk(16'h50, 16'h50, 8'hc8, 2'h0), 32'h50, 32'h4b00_f000, A};
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 8'h0; pwdata = 32'h0;
    rpt_valid = 0; rpt = '0; slow = 0; err_total = 0; samples_checked = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ADDR_CTRL, 32'h0);
    check("ctrl reset", q, CTRL_RESET);
    apb(1'b1, ADDR_BASE, 32'h100);
    for (int i = 0; i < 18; i++) begin
      w = 64 + 4 * i;
      slow <= i[0];
      apb(1'b1, ADDR_CTRL, tbl[i].ctrl);
      i_rxdwb_mem.mem[w] = 32'h0;
      i_rxdwb_mem.mem[w+1] = tbl[i].pre;
      i_rxdwb_mem.mem[w+2] = 32'h5a00_0000 + i;
      i_rxdwb_mem.mem[w+3] = 32'hc0de_0000 + i;
      send(tbl[i].r);
      wait_own(w);
      check("length word", i_rxdwb_mem.mem[w], tbl[i].elen);
      check("status word", i_rxdwb_mem.mem[w+1] & tbl[i].mask, tbl[i].estat);
      check("user word", i_rxdwb_mem.mem[w+3], 32'hc0de_0000 + i);
      check("buffer pointer", buf_ptr, 32'h5a00_0000 + i);
      apb(1'b0, ADDR_LAST1, 32'h0);
      check("last status reg", q & tbl[i].mask, tbl[i].estat);
      apb(1'b0, ADDR_LAST0, 32'h0);
      check("last length reg", q, tbl[i].elen);
    end
    apb(1'b0, ADDR_BASE, 32'h0);
    check("base advance", q, 32'h220);
    apb(1'b0, ADDR_STAT, 32'h0);
    check("idle status reg", q, 32'h4);
    // Entry still held by the host: the block must poll and not write
    w = 136;
    apb(1'b1, ADDR_CTRL, 32'h2003);
    i_rxdwb_mem.mem[w] = 32'h0;
    i_rxdwb_mem.mem[w+1] = 32'h0000_f000;
    i_rxdwb_mem.mem[w+2] = 32'h5a5a_0000;
    send(tbl[0].r);
    repeat (30) @(posedge pclk);
    check("unowned status", i_rxdwb_mem.mem[w+1], 32'h0000_f000);
    check("pointer valid in poll", {31'h0, buf_ptr_valid}, 32'h0);
    apb(1'b0, ADDR_STAT, 32'h0);
    check("busy status reg", q, 32'h5);
    // Switch to 16-bit structures mid-poll: match bits must stay clear
    apb(1'b1, ADDR_CTRL, 32'h2000);
    i_rxdwb_mem.mem[w+1] <= 32'h8000_f000;
    wait_own(w);
    check("late owned status", i_rxdwb_mem.mem[w+1], 32'h0300_f000);
    check("late buffer pointer", buf_ptr, 32'h5a5a_0000);
    // Sixteen-bit format: reports are refused
    apb(1'b1, ADDR_CTRL, 32'h2000);
    @(posedge pclk);
    rpt_valid <= 1'b1;
    repeat (10) @(posedge pclk);
    check("format 0 ready", {31'h0, rpt_ready}, 32'h0);
    rpt_valid <= 1'b0;
    apb(1'b0, 8'h40, 32'h0);
    check("unmapped error", {31'h0, e}, 32'h1);
    check("unmapped data", q, 32'h0);
    // Reset in mid-run clears the control register
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ADDR_CTRL, 32'h0);
    check("ctrl after reset", q, CTRL_RESET);
    check("memory rule breaks", 32'(viol), 32'h0);
    give_verdict();
  end
endmodule : tb_top
